// ---- icr_cfg.svh ----
// Constants for the alignment-sequence configuration capture bank
// Contract
// (RQ1) Lane 0 total bits per sample kept as value minus one in five bits.
// (RQ2) Lane 0 standard version captured into a three-bit read-only field.
// (RQ3) Lane 0 samples per converter per frame kept as count minus one.
// (RQ4) Lane 0 density format kept in one bit, one meaning high density.
// (RQ5) Lane 0 control words per frame captured; zero is the only valid value.
// (RQ6) Both reserved configuration octets of lane 0 kept unchanged, one register each.
// (RQ7) Each lane's received checksum octet latched into its own read-only register.
// (RQ8) Receiver computes its own checksum per lane and shows it read-only.
// (RQ9) Checksum method chosen by bit 6 of the link control register.
// (RQ10) Transmitter uses the same method, so computed and received sums match.
// (RQ11) Each lane identifier kept in five bits, upper three bits read zero. Only lanes 1 to 3 have an identifier register; lane 0's is not readable.
// (RQ12) Fields reset to zero, change only on a new sequence, ignore writes.
`ifndef ICR_CFG_SVH
`define ICR_CFG_SVH

// Register indices; the bus byte address is four times the index
`define ICR_IDX_LINK_CTRL 11'h300
`define ICR_IDX_SUB_BITS 11'h408
`define ICR_IDX_VER_SAMP 11'h409
`define ICR_IDX_DENS_CW 11'h40A
`define ICR_IDX_RES_ONE 11'h40B
`define ICR_IDX_RES_TWO 11'h40C
`define ICR_IDX_L0_RSUM 11'h40D
`define ICR_IDX_L0_CSUM 11'h40E
`define ICR_IDX_L1_ID 11'h412
`define ICR_IDX_L1_RSUM 11'h415
`define ICR_IDX_L1_CSUM 11'h416
`define ICR_IDX_L2_ID 11'h41A
`define ICR_IDX_L2_RSUM 11'h41D
`define ICR_IDX_L2_CSUM 11'h41E
`define ICR_IDX_L3_ID 11'h422
`define ICR_IDX_L3_RSUM 11'h425
`define ICR_IDX_L3_CSUM 11'h426

// Field positions
`define ICR_CTRL_SUM_MODE_BIT 6
`define ICR_RESET_OCTET 8'h00

// Octet positions inside the configuration block of the sequence
`define ICR_OCT_LANE_ID 4'h2
`define ICR_OCT_SUB_BITS 4'h8
`define ICR_OCT_VER_SAMP 4'h9
`define ICR_OCT_DENS_CW 4'hA
`define ICR_OCT_RES_ONE 4'hB
`define ICR_OCT_RES_TWO 4'hC
`define ICR_OCT_CHECKSUM 4'hD

// Number of lanes kept by this bank
`define ICR_LANES 4

`endif

// ---- icr_pkg.sv ----
// Types shared by the configuration capture bank
package icr_pkg;

    // One configuration octet as delivered by the lane receiver
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] octet;
    } icr_octet_type;

    // Committed results of one lane's alignment sequence
    typedef struct packed {
        logic seen;
        logic [4:0] lane_id;
        logic [7:0] received_sum;
        logic [7:0] computed_sum;
        logic [7:0] sub_bits;
        logic [7:0] ver_samp;
        logic [7:0] dens_cw;
        logic [7:0] res_one;
        logic [7:0] res_two;
    } icr_lane_type;

    // Collector states
    typedef enum logic [1:0] {
        ICR_IDLE = 2'b01,
        ICR_COLLECT = 2'b10
    } icr_state_type;

endpackage

// ---- icr_field_sum.sv ----
// Sum of the packed parameter fields carried by one configuration octet
`timescale 1ns/1ps
module icr_field_sum
    import icr_pkg::*;
(
    input wire logic [3:0] i_index, // Octet position in the block
    input wire logic [7:0] i_octet, // Octet value
    output logic [7:0] o_part // Field sum of this octet, modulo 256
);
    // Each octet may pack several fields; the field method adds them separately
    always_comb begin
        unique case (i_index)
            4'h1: o_part = {4'h0, i_octet[7:4]} + {4'h0, i_octet[3:0]};
            4'h2: o_part = {7'h00, i_octet[6]} + {7'h00, i_octet[5]} + {3'h0, i_octet[4:0]};
            4'h3: o_part = {7'h00, i_octet[7]} + {3'h0, i_octet[4:0]};
            4'h7: o_part = {6'h00, i_octet[7:6]} + {3'h0, i_octet[4:0]};
            4'h8: o_part = {5'h00, i_octet[7:5]} + {3'h0, i_octet[4:0]};
            4'h9: o_part = {5'h00, i_octet[7:5]} + {3'h0, i_octet[4:0]};
            4'hA: o_part = {7'h00, i_octet[7]} + {3'h0, i_octet[4:0]};
            4'h0, 4'h4, 4'h5, 4'h6, 4'hB, 4'hC: o_part = i_octet;
            default: o_part = 8'h00; // Checksum octet and beyond add nothing
        endcase
    end
endmodule

// ---- icr_lane_capture.sv ----
// Collects one lane's configuration block and commits it when complete
`timescale 1ns/1ps
`include "icr_cfg.svh"
module icr_lane_capture
    import icr_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_srst, // Synchronous reset, active high
    input wire icr_octet_type i_oct, // Incoming configuration octet
    input wire logic [7:0] i_part, // Field sum of the current octet
    input wire logic i_sum_mode, // Checksum method select
    output logic [3:0] o_index, // Position the next octet will take
    output icr_lane_type o_res // Committed results
);
    icr_state_type state;
    icr_lane_type shadow;
    logic [7:0] octet_sum;
    logic [7:0] field_sum;

    // Position counter; a first-octet marker always restarts the block
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= ICR_IDLE;
            o_index <= 4'h0;
        end else if (i_oct.valid && i_oct.first) begin
            state <= ICR_COLLECT;
            o_index <= 4'h1;
        end else if (i_oct.valid && state == ICR_COLLECT) begin
            if (o_index == `ICR_OCT_CHECKSUM) begin
                state <= ICR_IDLE;
                o_index <= 4'h0;
            end else begin
                o_index <= o_index + 4'h1;
            end
        end
    end

    // Both running sums are kept so the method may change mid-block
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            octet_sum <= 8'h00;
            field_sum <= 8'h00;
        end else if (i_oct.valid && i_oct.first) begin
            octet_sum <= i_oct.octet;
            field_sum <= i_part;
        end else if (i_oct.valid && state == ICR_COLLECT && o_index != `ICR_OCT_CHECKSUM) begin
            octet_sum <= octet_sum + i_oct.octet;
            field_sum <= field_sum + i_part;
        end
    end

    // Shadow copies; a broken block never reaches the visible fields
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            shadow <= '0;
        end else if (i_oct.valid && (i_oct.first || state == ICR_COLLECT)) begin
            unique case (i_oct.first ? 4'h0 : o_index)
                `ICR_OCT_LANE_ID: shadow.lane_id <= i_oct.octet[4:0]; // [RQ11]
                `ICR_OCT_SUB_BITS: shadow.sub_bits <= i_oct.octet; // [RQ1]
                `ICR_OCT_VER_SAMP: shadow.ver_samp <= i_oct.octet; // [RQ2] [RQ3]
                `ICR_OCT_DENS_CW: shadow.dens_cw <= i_oct.octet; // [RQ4] [RQ5]
                `ICR_OCT_RES_ONE: shadow.res_one <= i_oct.octet; // [RQ6]
                `ICR_OCT_RES_TWO: shadow.res_two <= i_oct.octet; // [RQ6]
                default: shadow.seen <= shadow.seen;
            endcase
        end
    end

    // Commit on the checksum octet only
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_res <= '0; // [RQ12]
        end else if (i_oct.valid && !i_oct.first && state == ICR_COLLECT
                     && o_index == `ICR_OCT_CHECKSUM) begin
            o_res <= shadow; // [RQ12]
            o_res.seen <= 1'b1;
            o_res.received_sum <= i_oct.octet; // [RQ7]
            o_res.computed_sum <= i_sum_mode ? octet_sum : field_sum; // [RQ8] [RQ9]
        end
    end
endmodule

// ---- icr_capture_bank.sv ----
// Alignment-sequence configuration capture bank with Avalon-MM register access
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "icr_cfg.svh"
module icr_capture_bank
    import icr_pkg::*;
(
    input wire logic i_clk, // System clock, 200 MHz
    input wire logic i_srst, // Synchronous reset, active high
    input wire icr_octet_type [`ICR_LANES-1:0] i_lane_oct, // Octets per lane
    input wire logic [12:0] i_avs_address, // Byte address
    input wire logic i_avs_read, // Read request
    input wire logic i_avs_write, // Write request
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte lanes
    output logic [31:0] o_avs_readdata, // Read data
    output logic o_avs_waitrequest, // Stall while high
    output logic [`ICR_LANES-1:0] o_sum_match // Computed equals received
);
    icr_lane_type [`ICR_LANES-1:0] lane_res;
    logic [`ICR_LANES-1:0][3:0] lane_index;
    logic [`ICR_LANES-1:0][7:0] lane_part;
    logic sum_mode;
    logic [10:0] reg_index;
    logic req;
    logic aligned;
    logic [7:0] next_read;

    // Per-lane collector and field adder
    for (genvar k = 0; k < `ICR_LANES; k++) begin : g_lane
        // A first-octet marker always means position 0, even when it cuts a block short
        icr_field_sum u_field_sum (
            .i_index(i_lane_oct[k].first ? 4'h0 : lane_index[k]),
            .i_octet(i_lane_oct[k].octet),
            .o_part(lane_part[k])
        );
        icr_lane_capture u_capture (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_oct(i_lane_oct[k]),
            .i_part(lane_part[k]),
            .i_sum_mode(sum_mode),
            .o_index(lane_index[k]),
            .o_res(lane_res[k])
        );
    end

    assign reg_index = i_avs_address[12:2];
    assign aligned = (i_avs_address[1:0] == 2'b00);
    assign req = (i_avs_read || i_avs_write) && o_avs_waitrequest;

    // Read decode; lane 0 supplies all link-wide parameters
    always_comb begin
        next_read = 8'h00;
        if (aligned) begin
            unique case (reg_index)
                `ICR_IDX_LINK_CTRL: next_read = {1'b0, sum_mode, 6'h00};
                `ICR_IDX_SUB_BITS: next_read = lane_res[0].sub_bits; // [RQ1]
                `ICR_IDX_VER_SAMP: next_read = lane_res[0].ver_samp; // [RQ2] [RQ3]
                `ICR_IDX_DENS_CW: next_read = {lane_res[0].dens_cw[7], 2'b00,
                                               lane_res[0].dens_cw[4:0]}; // [RQ4] [RQ5]
                `ICR_IDX_RES_ONE: next_read = lane_res[0].res_one; // [RQ6]
                `ICR_IDX_RES_TWO: next_read = lane_res[0].res_two; // [RQ6]
                `ICR_IDX_L0_RSUM: next_read = lane_res[0].received_sum; // [RQ7]
                `ICR_IDX_L0_CSUM: next_read = lane_res[0].computed_sum; // [RQ8]
                `ICR_IDX_L1_ID: next_read = {3'h0, lane_res[1].lane_id}; // [RQ11]
                `ICR_IDX_L1_RSUM: next_read = lane_res[1].received_sum; // [RQ7]
                `ICR_IDX_L1_CSUM: next_read = lane_res[1].computed_sum; // [RQ8]
                `ICR_IDX_L2_ID: next_read = {3'h0, lane_res[2].lane_id}; // [RQ11]
                `ICR_IDX_L2_RSUM: next_read = lane_res[2].received_sum; // [RQ7]
                `ICR_IDX_L2_CSUM: next_read = lane_res[2].computed_sum; // [RQ8]
                `ICR_IDX_L3_ID: next_read = {3'h0, lane_res[3].lane_id}; // [RQ11]
                `ICR_IDX_L3_RSUM: next_read = lane_res[3].received_sum; // [RQ7]
                `ICR_IDX_L3_CSUM: next_read = lane_res[3].computed_sum; // [RQ8]
                default: next_read = 8'h00; // Unmapped reads return zero
            endcase
        end
    end

    // One wait state per access keeps the read mux off the bus path
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !req;
        end
    end

    // Read data registered at the edge that drops waitrequest
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (req && i_avs_read) begin
            o_avs_readdata <= {24'h00_0000, next_read};
        end
    end

    // Only the checksum method bit is writable; capture fields ignore writes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sum_mode <= 1'b0;
        end else if (req && i_avs_write && aligned && i_avs_byteenable[0]
                     && reg_index == `ICR_IDX_LINK_CTRL) begin
            sum_mode <= i_avs_writedata[`ICR_CTRL_SUM_MODE_BIT]; // [RQ9] [RQ12]
        end
    end

    // Per-lane agreement between both checksums, once a block has arrived
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sum_match <= '0;
        end else begin
            for (int k = 0; k < `ICR_LANES; k++) begin
                o_sum_match[k] <= lane_res[k].seen
                                  && lane_res[k].received_sum == lane_res[k].computed_sum; // [RQ10]
            end
        end
    end
endmodule

// ---- icr_xmit_model.sv ----
// Behavioural far-end transmitter sending one configuration block
`timescale 1ns/1ps
module icr_xmit_model
    import icr_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_go, // Start a block
    input wire logic i_gap, // Idle slot after each octet
    input wire logic [13:0][7:0] i_blk, // Octets 0..13, 13 is the checksum
    output icr_octet_type o_oct, // Octet stream
    output logic o_busy // Block in flight
);
    initial begin
        o_oct = '0;
        o_busy = 1'b0;
    end
    // Idle slots carry the inverse of the last octet so stale data is never mistaken
    always @(posedge i_clk) begin
        if (i_go && !o_busy) begin
            o_busy <= 1'b1;
            for (int i = 0; i < 14; i++) begin
                o_oct <= '{1'b1, i == 0, i_blk[i]}; // Checksum as given
                @(posedge i_clk);
                if (i_gap) begin
                    o_oct <= '{1'b0, 1'b0, ~i_blk[i]};
                    @(posedge i_clk);
                end
            end
            o_oct <= '{1'b0, 1'b0, ~i_blk[13]};
            o_busy <= 1'b0;
        end
    end
endmodule

// ---- icr_capture_bank_asserts.sv ----
// Port-level timing and read-data checks for the capture bank
`timescale 1ns/1ps
`include "icr_cfg.svh"
module icr_capture_bank_asserts
    import icr_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_srst, // Reset
    input wire icr_octet_type [`ICR_LANES-1:0] i_lane_oct, // Octets
    input wire logic [12:0] i_avs_address, // Address
    input wire logic i_avs_read, // Read
    input wire logic i_avs_write, // Write
    input wire logic [31:0] i_avs_writedata, // Write data
    input wire logic [3:0] i_avs_byteenable, // Byte lanes
    input wire logic [31:0] o_avs_readdata, // Read data
    input wire logic o_avs_waitrequest, // Stall
    input wire logic [`ICR_LANES-1:0] o_sum_match // Sum flags
);
    logic [3:0] vld;
    logic rq;
    logic rdone;
    // Octet strobes; a sum flag may only move two edges after one of them
    for (genvar g = 0; g < 4; g++) assign vld[g] = i_lane_oct[g].valid;
    assign rq = i_avs_read | i_avs_write;
    assign rdone = i_avs_read & ~o_avs_waitrequest;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_reset_idle: assert property (disable iff (1'b0) i_srst |=> o_avs_waitrequest &&
        o_avs_readdata == 32'h0 && o_sum_match == 4'h0) else $error("reset state wrong");
    a_ack_next: assert property (rq && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("access not answered in one cycle");
    a_idle_wait: assert property (!rq |-> o_avs_waitrequest)
        else $error("waitrequest low while idle");
    a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_rdata_hold: assert property ($changed(o_avs_readdata) |-> rdone || $past(i_srst))
        else $error("read data moved without a read");
    a_upper_zero: assert property (rdone |-> o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_lid_gap: assert property (rdone && i_avs_address[12:2] inside {`ICR_IDX_L1_ID,
        `ICR_IDX_L2_ID, `ICR_IDX_L3_ID} |-> o_avs_readdata[7:5] == 3'h0)
        else $error("lane id upper bits set");
    a_dens_gap: assert property (rdone && i_avs_address[12:2] == `ICR_IDX_DENS_CW
        |-> o_avs_readdata[6:5] == 2'h0) else $error("density gap bits set");
    a_mode_only: assert property (rdone && i_avs_address[12:2] == `ICR_IDX_LINK_CTRL
        |-> (o_avs_readdata & ~32'h40) == 32'h0) else $error("control extra bits");
    a_match_cause: assert property ($changed(o_sum_match) |-> $past(|vld, 2) || $past(i_srst))
        else $error("sum flag moved without a block");
    c_read: cover property (rdone);
    c_write: cover property (i_avs_write && !o_avs_waitrequest);
    c_match: cover property ($rose(o_sum_match[0]));
endmodule
bind icr_capture_bank icr_capture_bank_asserts i_chk (.i_clk, .i_srst, .i_lane_oct,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_sum_match);

// ---- icr_capture_bank_tb.sv ----
// Self-checking bench for the configuration capture bank
`timescale 1ns/1ps
module icr_capture_bank_tb import icr_pkg::*;;
    typedef struct packed {logic [10:0] idx; logic [7:0] val;} icr_row_type;
    logic i_clk;
    logic i_srst;
    icr_octet_type [3:0] lane_oct;
    logic [12:0] adr;
    logic rd_q, wr_q, wait_q;
    logic [31:0] wdat, rdat, rd;
    logic [3:0] match, go, busy;
    logic [3:0][13:0][7:0] blk;
    int n_errors = 0;
    int n_tests = 0;
    // Field-sum mode values after the first block on every lane
    icr_row_type rows [16] = '{'{11'h408, 8'h2F}, '{11'h409, 8'h21}, '{11'h40A, 8'h80},
        '{11'h40B, 8'hA5}, '{11'h40C, 8'h5A}, '{11'h40D, 8'h12}, '{11'h40E, 8'h12},
        '{11'h412, 8'h01}, '{11'h415, 8'h13}, '{11'h416, 8'h13}, '{11'h41A, 8'h02},
        '{11'h41D, 8'h14}, '{11'h41E, 8'h14}, '{11'h422, 8'h03}, '{11'h425, 8'h15}, '{11'h426, 8'h15}};
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    icr_capture_bank i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_lane_oct(lane_oct),
        .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_q), .o_sum_match(match));
    // Even lanes leave idle slots between octets, odd lanes send back to back
    for (genvar k = 0; k < 4; k++) begin
        icr_xmit_model i_tx (.i_clk(i_clk), .i_go(go[k]), .i_gap(k % 2 == 0), .i_blk(blk[k]),
            .o_oct(lane_oct[k]), .o_busy(busy[k]));
    end
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [10:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        rd_q <= !wr;
        wr_q <= wr;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, wd};
        do begin
            @(posedge i_clk);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        rd = rdat;
        if (n >= 50) n_errors++;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask
    function automatic logic [13:0][7:0] mk(input int k, input logic [7:0] s);
        mk = '0;
        mk[2] = 8'h80 | 8'(k);
        mk[8] = 8'h2F;
        mk[9] = 8'h21;
        mk[10] = 8'hE0;
        mk[11] = 8'hA5;
        mk[12] = 8'h5A;
        mk[13] = s;
    endfunction
    // Sum flags settle two edges after the checksum octet is taken
    task automatic send(input logic [3:0] l);
        int n;
        n = 0;
        @(posedge i_clk);
        go <= l;
        @(posedge i_clk);
        go <= 4'h0;
        do begin
            @(posedge i_clk);
            n++;
        end while (busy !== 4'h0 && n < 200);
        if (n >= 200) n_errors++;
        repeat (2) @(posedge i_clk);
    endtask
    initial begin
        #100000;
        n_errors++;
        test_done;
    end
    initial begin
        {i_srst, go, rd_q, wr_q, adr, wdat, blk} = {1'b1, 4'h0, 2'b00, 13'h0, 32'h0, 448'h0};
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        foreach (rows[i]) begin
            bus(0, rows[i].idx, 8'h0);
            chk("reset value", rd, 32'h0);
        end
        for (int k = 0; k < 4; k++) blk[k] <= mk(k, 8'h12 + 8'(k));
        send(4'hF);
        chk("sum match", {28'h0, match}, 32'hF);
        foreach (rows[i]) begin
            bus(0, rows[i].idx, 8'h0);
            chk("register", rd, {24'h0, rows[i].val});
        end
        bus(1, 11'h409, 8'hFF);
        bus(0, 11'h409, 8'h0);
        chk("written field", rd, 32'h21);
        bus(0, 11'h410, 8'h0);
        chk("unmapped", rd, 32'h0);
        // Raw-octet mode: lane 0 agrees, lane 1 still sends a field sum
        bus(1, 11'h300, 8'hFF);
        bus(0, 11'h300, 8'h0);
        chk("mode bit", rd, 32'h40);
        blk[0] <= mk(0, 8'hAF);
        blk[1] <= mk(1, 8'h13);
        send(4'h3);
        chk("raw match", {28'h0, match}, 32'hD);
        bus(0, 11'h40E, 8'h0);
        chk("lane0 raw sum", rd, 32'hAF);
        bus(0, 11'h416, 8'h0);
        chk("lane1 raw sum", rd, 32'hB0);
        bus(0, 11'h415, 8'h0);
        chk("lane1 received", rd, 32'h13);
        i_srst <= 1'b1;
        @(posedge i_clk);
        i_srst <= 1'b0;
        bus(0, 11'h40E, 8'h0);
        chk("cleared sum", rd, 32'h0);
        chk("cleared match", {28'h0, match}, 32'h0);
        test_done;
    end
endmodule
